// File: pkg/fsq_pkg.sv
package fsq_pkg;

    localparam int unsigned CLK_MHZ       = 125;
    localparam int unsigned ADDR_W        = 20;
    // Recovery waits after an emergency exit, in microseconds
    localparam int unsigned REC_BANK_US   = 100;
    localparam int unsigned REC_SEG_US    = 6;
    localparam int unsigned REC_BANK_CYC  = REC_BANK_US * CLK_MHZ;
    localparam int unsigned REC_SEG_CYC   = REC_SEG_US * CLK_MHZ;
    // Array operation lengths, plain defaults in cycles
    localparam int unsigned WRITE_CYC     = 64;
    localparam int unsigned SEG_ERASE_CYC = 2048;
    localparam int unsigned BANK_ERASE_CYC = 4096;
    // Information memory window and top of the low 64K map
    localparam logic [19:0] INFO_LO       = 20'h01800;
    localparam logic [19:0] INFO_HI       = 20'h019FF;
    localparam logic [19:0] LOW64K_TOP    = 20'h0FFFF;

    // Operation selected in the flash control bits
    typedef enum logic [1:0] {
        FSQ_OP_NONE  = 2'b00,
        FSQ_OP_WRITE = 2'b01,
        FSQ_OP_SEG   = 2'b10,
        FSQ_OP_BANK  = 2'b11
    } fsq_op_e;

    typedef enum logic [2:0] {
        FSQ_IDLE    = 3'b000,
        FSQ_WRITE   = 3'b001,
        FSQ_SEG     = 3'b010,
        FSQ_BANK    = 3'b011,
        FSQ_RECOVER = 3'b100
    } fsq_state_e;

    // One CPU access toward flash
    typedef struct packed {
        logic              valid;
        logic              write;
        logic              fetch;
        logic [ADDR_W-1:0] addr;
    } fsq_acc_s;

    // Commands toward the flash array
    typedef struct packed {
        logic              prog;
        logic              seg_erase;
        logic              bank_erase;
        logic              info_erase;
        logic [ADDR_W-1:0] addr;
    } fsq_arr_s;

endpackage : fsq_pkg

// File: verif/fsq_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module fsq_cpu_model
    import fsq_pkg::*;
(
    input  wire logic ref_clk_in,
    input  wire logic ready_in,
    output fsq_acc_s  acc_out
);
    // Bus starts idle at time zero
    initial acc_out = '0;

    // A released bus shows inverted values, so a stale request is never mistaken for a live one
    task automatic idle_bus();
        @(negedge ref_clk_in);
        acc_out = '{1'b0, ~acc_out.write, ~acc_out.fetch, ~acc_out.addr};
    endtask : idle_bus

    // Only main and RAM addresses are fetched; erase and level-change code runs from RAM
    task automatic present(input logic wr, input logic fe, input logic [ADDR_W-1:0] ad);
        @(negedge ref_clk_in);
        acc_out = '{1'b1, wr, fe, ad};
    endtask : present

    // Request held until ready is seen high before a rising edge, then released
    task automatic access(input logic wr, input logic fe, input logic [ADDR_W-1:0] ad);
        present(wr, fe, ad);
        #1;
        // No local limit: a stuck ready is left to the bench watchdog, which fails the run
        while (ready_in !== 1'b1) begin
            @(negedge ref_clk_in);
            #1;
        end
        @(posedge ref_clk_in);
        idle_bus();
    endtask : access
endmodule : fsq_cpu_model
`default_nettype wire

// File: verif/test_fsq_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module test_fsq_sequencer;
    import fsq_pkg::*;
    localparam int unsigned REC_N = 20;
    logic     ref_clk_in = 1'b0;
    logic     rst_in = 1'b1;
    logic     emergency_exit_bit = 1'b0, irq = 1'b0, global_interrupt_enable = 1'b0, mon = 1'b0, flag = 1'b0, lvl = 1'b0;
    logic     ready, irq_take, busy, rec, unrel, corrupt, low_map;
    fsq_op_e  op = FSQ_OP_NONE;
    fsq_acc_s acc;
    fsq_arr_s arr;
    int       miscompares = 0;
    int       samples_checked = 0;
    int       n;

    // Free-running clock, 8 ns period
    always #4 ref_clk_in = ~ref_clk_in;

    fsq_cpu_model cpu (.ref_clk_in(ref_clk_in), .ready_in(ready), .acc_out(acc));
    fsq_sequencer #(.REC_BANK_CYCLES(REC_N)) uut (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .acc_in(acc), .acc_ready_out(ready), .op_mode_in(op),
        .emergency_exit_bit_in(emergency_exit_bit), .irq_pending_in(irq), .global_interrupt_enable_in(global_interrupt_enable),
        .irq_take_out(irq_take), .supply_voltage_monitor_en_in(mon), .monitor_settle_delay_flag_in(flag),
        .core_level_change_in(lvl), .arr_out(arr), .busy_out(busy), .recovering_out(rec),
        .read_unreliable_out(unrel), .read_corrupt_out(corrupt), .info_low_map_out(low_map));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    // Counts falling edges while busy (sel 0) or recovering (sel 1) stays high
    task automatic cnt_high(input bit sel, output int k);
        k = 0;
        while ((sel ? rec : busy) === 1'b1 && k < 5000) begin
            k++;
            @(negedge ref_clk_in);
        end
    endtask : cnt_high

    // Emergency exit for one cycle, then the abort outcome and recovery length
    task automatic abort_and_check(input int exp_rec);
        @(negedge ref_clk_in);
        emergency_exit_bit = 1'b1;
        @(negedge ref_clk_in);
        emergency_exit_bit = 1'b0;
        chk(busy, 0);
        chk(unrel, 1);
        chk({rec, ready}, 32'h2);
        cnt_high(1'b1, n);
        chk(n, exp_rec);
    endtask : abort_and_check

    task automatic t_write();
        op = FSQ_OP_WRITE;
        cpu.access(1'b1, 1'b0, 20'h04400);
        chk(arr.prog, 1);
        cnt_high(1'b0, n);
        chk(n, WRITE_CYC);
        chk({busy, arr.prog}, 0);
    endtask : t_write

    // Info read right before the trigger; fetch refused and interrupts still taken mid-erase
    task automatic t_bank_abort();
        op = FSQ_OP_BANK;
        cpu.access(1'b0, 1'b0, INFO_LO);
        cpu.access(1'b1, 1'b0, 20'h08000);
        chk({arr.bank_erase, arr.info_erase}, 32'h3);
        irq = 1'b1;
        #1;
        chk(irq_take, 0);
        cpu.present(1'b0, 1'b1, 20'h08000);
        global_interrupt_enable = 1'b1;
        #1;
        chk(ready, 0);
        chk(irq_take, 1);
        cpu.idle_bus();
        irq = 1'b0;
        global_interrupt_enable = 1'b0;
        abort_and_check(REC_N);
    endtask : t_bank_abort

    // Main dummy read after an info read keeps info out of a bank erase; then a segment abort
    task automatic t_seg_abort();
        op = FSQ_OP_BANK;
        cpu.access(1'b0, 1'b0, INFO_LO);
        cpu.access(1'b0, 1'b0, 20'h05000);
        cpu.access(1'b1, 1'b0, 20'h05000);
        chk({arr.bank_erase, arr.info_erase}, 32'h2);
        abort_and_check(REC_N);
        op = FSQ_OP_SEG;
        cpu.access(1'b1, 1'b0, 20'h05000);
        chk({arr.seg_erase, arr.info_erase}, 32'h2);
        chk(unrel, 0);
        abort_and_check(REC_SEG_CYC);
    endtask : t_seg_abort

    task automatic t_corrupt();
        op = FSQ_OP_NONE;
        mon = 1'b1;
        cpu.access(1'b0, 1'b0, 20'h06000);
        chk(corrupt, 0);
        // The flag must rise in the very cycle the read is taken; ready is high in idle
        cpu.present(1'b0, 1'b0, 20'h06000);
        flag = 1'b1;
        @(posedge ref_clk_in);
        cpu.idle_bus();
        chk(corrupt, 1);
        cpu.access(1'b0, 1'b0, 20'h06000);
        chk(corrupt, 0);
        lvl = 1'b1;
        cpu.access(1'b0, 1'b0, 20'h06002);
        chk(corrupt, 1);
        lvl = 1'b0;
        flag = 1'b0;
        mon = 1'b0;
    endtask : t_corrupt

    // Info read by code fetched above 64K clears the low-map flag; from the low map it sets it
    task automatic t_info_map();
        op = FSQ_OP_NONE;
        cpu.access(1'b0, 1'b1, 20'h10000);
        cpu.access(1'b0, 1'b0, INFO_HI);
        chk(low_map, 0);
        cpu.access(1'b0, 1'b1, 20'h04400);
        cpu.access(1'b0, 1'b0, INFO_LO);
        chk(low_map, 1);
    endtask : t_info_map

    task automatic give_verdict();
        if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    // Watchdog sized well above the longest expected run
    initial begin
        repeat (30000) @(posedge ref_clk_in);
        miscompares++;
        give_verdict();
    end

    // Reset held for 16 cycles, then each scenario in turn
    initial begin
        repeat (16) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        rst_in = 1'b0;
        t_write();
        t_bank_abort();
        t_seg_abort();
        t_corrupt();
        t_info_map();
        give_verdict();
    end
endmodule : test_fsq_sequencer
`default_nettype wire

// File: verilog/fsq_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module fsq_sequencer
    import fsq_pkg::*;
#(
    parameter int unsigned REC_BANK_CYCLES = REC_BANK_CYC
) (
    input  wire logic     ref_clk_in,
    input  wire logic     rst_in,
    input  wire fsq_acc_s acc_in,
    output logic          acc_ready_out,
    input  wire fsq_op_e  op_mode_in,
    input  wire logic     emergency_exit_bit_in,
    input  wire logic     irq_pending_in,
    input  wire logic     global_interrupt_enable_in,
    output logic          irq_take_out,
    input  wire logic     supply_voltage_monitor_en_in,
    input  wire logic     monitor_settle_delay_flag_in,
    input  wire logic     core_level_change_in,
    output fsq_arr_s      arr_out,
    output logic          busy_out,
    output logic          recovering_out,
    output logic          read_unreliable_out,
    output logic          read_corrupt_out,
    output logic          info_low_map_out
);

    typedef struct packed {
        fsq_state_e  st;
        logic [15:0] tmr;
        logic        last_info_rd;
        logic        unrel;
        logic        corrupt;
        logic        flag_prev;
        logic        low_map;
        logic        code_low;
        fsq_arr_s    arr;
    } fsq_regs_s;

    fsq_regs_s q;
    fsq_regs_s d;
    logic      acc_go;
    logic      start;
    logic      abort;

    // Address in the information memory window
    function automatic logic is_info(input logic [ADDR_W-1:0] a);
        return (a >= INFO_LO) && (a <= INFO_HI);
    endfunction : is_info

    function automatic logic is_busy(input fsq_state_e s);
        return (s == FSQ_WRITE) || (s == FSQ_SEG) || (s == FSQ_BANK);
    endfunction : is_busy

    // Refuse all accesses while recovering, and fetches during bank erase
    always_comb begin
        acc_ready_out = !((q.st == FSQ_RECOVER) ||
                          (q.st == FSQ_BANK && acc_in.fetch));
    end

    assign acc_go = acc_in.valid && acc_ready_out;
    assign start  = (q.st == FSQ_IDLE) && acc_go && acc_in.write && (op_mode_in != FSQ_OP_NONE);
    assign abort  = is_busy(q.st) && emergency_exit_bit_in;

    // Next-state logic for the whole sequencer
    always_comb begin
        d = q;
        d.corrupt   = 1'b0;
        d.flag_prev = monitor_settle_delay_flag_in;
        // Core level moves while a read is in flight corrupt that read
        if (supply_voltage_monitor_en_in && acc_go && !acc_in.write &&
            ((monitor_settle_delay_flag_in && !q.flag_prev) ||
             core_level_change_in)) begin
            d.corrupt = 1'b1;
        end
        // Track where code runs: the latest fetch tells which map the reader sits in
        if (acc_go && acc_in.fetch) begin
            d.code_low = (acc_in.addr <= LOW64K_TOP);
        end
        // Info reads record whether the issuing code sits in the low 64K map
        if (acc_go && !acc_in.write && is_info(acc_in.addr)) begin
            d.low_map = q.code_low;
        end
        // Remember whether the latest access was an info read
        if (acc_go) begin
            d.last_info_rd = !acc_in.write && is_info(acc_in.addr);
        end
        case (q.st)
            FSQ_IDLE: begin
                if (start) begin
                    d.unrel    = 1'b0;
                    d.arr.addr = acc_in.addr;
                    case (op_mode_in)
                        FSQ_OP_WRITE: begin
                            d.st       = FSQ_WRITE;
                            d.tmr      = 16'(WRITE_CYC);
                            d.arr.prog = 1'b1;
                        end
                        FSQ_OP_SEG: begin
                            d.st            = FSQ_SEG;
                            d.tmr           = 16'(SEG_ERASE_CYC);
                            d.arr.seg_erase = 1'b1;
                        end
                        default: begin
                            d.st             = FSQ_BANK;
                            d.tmr            = 16'(BANK_ERASE_CYC);
                            d.arr.bank_erase = 1'b1;
                            // A preceding info read drags info into the erase
                            d.arr.info_erase = q.last_info_rd;
                        end
                    endcase
                end
            end
            FSQ_WRITE, FSQ_SEG, FSQ_BANK: begin
                if (abort) begin
                    // Stop the array now; reads stay suspect afterwards
                    d.arr       = '0;
                    d.unrel     = 1'b1;
                    d.st        = FSQ_RECOVER;
                    d.tmr       = (q.st == FSQ_BANK) ? 16'(REC_BANK_CYCLES) :
                                  (q.st == FSQ_SEG)  ? 16'(REC_SEG_CYC) : 16'h0001;
                end else if (q.tmr == 16'h0001) begin
                    d.arr = '0;
                    d.st  = FSQ_IDLE;
                end else begin
                    d.tmr = q.tmr - 16'h0001;
                end
            end
            FSQ_RECOVER: begin
                // Hold off flash until the array has settled after abort
                if (q.tmr == 16'h0001) begin
                    d.st = FSQ_IDLE;
                end else begin
                    d.tmr = q.tmr - 16'h0001;
                end
            end
            default: begin
                d.st = FSQ_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            q         <= '0;
            q.st      <= FSQ_IDLE;
            q.low_map <= 1'b1;
            q.code_low <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Interrupts pass straight through; erase never masks them
    assign irq_take_out        = irq_pending_in && global_interrupt_enable_in;
    assign arr_out             = q.arr;
    assign busy_out            = is_busy(q.st);
    assign recovering_out      = (q.st == FSQ_RECOVER);
    assign read_unreliable_out = q.unrel;
    assign read_corrupt_out    = q.corrupt;
    assign info_low_map_out    = q.low_map;

    // Checks beside the logic they guard
    a_abort_stops: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        abort |=> !busy_out && arr_out.prog == 1'b0 && arr_out.bank_erase == 1'b0 && read_unreliable_out)
        else $error("emergency exit did not stop the operation");
    a_seg_recovery_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (abort && q.st == FSQ_SEG) |=> (recovering_out && !acc_ready_out) [*8])
        else $error("segment abort recovery too short");
    a_write_abort_short: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (abort && q.st == FSQ_WRITE) |=> recovering_out ##1 !recovering_out)
        else $error("write abort recovery wrong length");
    a_bank_no_fetch: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (q.st == FSQ_BANK && acc_in.fetch) |-> !acc_ready_out)
        else $error("fetch accepted during bank erase");
    a_info_erase_cause: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (start && op_mode_in == FSQ_OP_BANK) |=> arr_out.info_erase == $past(q.last_info_rd))
        else $error("info erase does not follow last access");
    a_irq_not_masked: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (busy_out && irq_pending_in && global_interrupt_enable_in) |-> irq_take_out)
        else $error("interrupt masked during erase");
    a_corrupt_flag: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (supply_voltage_monitor_en_in && acc_go && !acc_in.write && core_level_change_in)
        |=> read_corrupt_out)
        else $error("level change during read not flagged");
    a_busy_span: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (start && op_mode_in == FSQ_OP_WRITE) |=> busy_out [*8])
        else $error("busy not held during write");
    a_busy_end: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (busy_out && q.tmr == 16'h0001 && !emergency_exit_bit_in) |=> !busy_out && q.st == FSQ_IDLE)
        else $error("busy not cleared at completion");

    // Recovery must refuse the host outright, whatever operation was cut short
    a_recover_refuse: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        recovering_out |-> !acc_ready_out)
        else $error("access accepted during recovery");
    a_bank_recovery_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (abort && q.st == FSQ_BANK) |=> (recovering_out && !acc_ready_out) [*8])
        else $error("bank abort recovery too short");
    a_unrel_cleared: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        start |=> !read_unreliable_out)
        else $error("unreliable flag kept across a new operation");
    a_bank_info_clean: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (start && op_mode_in == FSQ_OP_BANK && !q.last_info_rd) |=> !arr_out.info_erase)
        else $error("info erased without a preceding info read");
    a_info_map_code: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (acc_go && !acc_in.write && is_info(acc_in.addr)) |=> info_low_map_out == $past(q.code_low))
        else $error("info read source map not tracked");
    a_corrupt_quiet: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !supply_voltage_monitor_en_in |=> !read_corrupt_out)
        else $error("read flagged corrupt with monitor off");
    a_flag_expiry: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (supply_voltage_monitor_en_in && acc_go && !acc_in.write &&
         monitor_settle_delay_flag_in && !q.flag_prev) |=> read_corrupt_out)
        else $error("settle delay expiry during read not flagged");

    c_bank_abort: cover property (@(posedge ref_clk_in) disable iff (rst_in) abort && q.st == FSQ_BANK);
    c_info_erase: cover property (@(posedge ref_clk_in) disable iff (rst_in) arr_out.info_erase);
    c_write_done: cover property (@(posedge ref_clk_in) disable iff (rst_in) $fell(busy_out) && !recovering_out);
    c_corrupt:    cover property (@(posedge ref_clk_in) disable iff (rst_in) read_corrupt_out);
    c_info_high:  cover property (@(posedge ref_clk_in) disable iff (rst_in)
        acc_go && !acc_in.write && is_info(acc_in.addr) && !q.code_low);

endmodule : fsq_sequencer
`default_nettype wire
